// ==== rtl/mms_consts.svh ====
// Constants of the mode select and pin map block.
// Assumes inclusion by bare name from rtl and tb files.
`ifndef MMS_CONSTS_SVH
`define MMS_CONSTS_SVH

// Register index and byte address (index times four)
`define MMS_RB_IDX      20'h0ff19
`define MMS_RB_ADDR     20'h3fc64
`define MMS_ADDR_W      20

// Readback layout
`define MMS_RB_HI_POS   7
`define MMS_RB_HI_LSB   6
`define MMS_RB_HI_VAL   2'h3
`define MMS_RB_MID_POS  5
`define MMS_RB_MID_LSB  3
`define MMS_RB_MID_VAL  3'h0
`define MMS_RB_SEL_POS  2
`define MMS_RB_RST      8'hc0

// Mode pin encodings
`define MMS_MODE_RST    3'h0
`define MMS_MODE1       3'h1
`define MMS_MODE2       3'h2
`define MMS_MODE3       3'h3
`define MMS_MODE4       3'h4

// Page select encodings
`define MMS_PG_CODE     2'h0
`define MMS_PG_DATA     2'h1
`define MMS_PG_EXT      2'h2
`define MMS_PG_STACK    2'h3

// Settle count ending the wait; mode capture falls on the fourth edge after reset release
`define MMS_SETTLE_CYC  2'h2

`endif

// ==== rtl/mms_pkg.sv ====
// Types shared by the mode select and pin map block.
// Assumes nothing beyond a SystemVerilog compiler.
package mms_pkg;

  typedef enum logic [1:0] {
    MMS_LK_SETTLE,
    MMS_LK_CAPTURE,
    MMS_LK_HELD
  } mms_lock_t;

  typedef logic [2:0] mms_mode_t;

endpackage : mms_pkg

// ==== rtl/mms_sync.sv ====
// Two-flop synchroniser for a bus of pin levels.
// Assumes each bit is an independent level.
`timescale 1ns/1ns
`default_nettype none

module mms_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Levels
  input  wire logic [W-1:0] din,
  output var  logic [W-1:0] dout
);

  logic [W-1:0] meta_r;

  // First stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= '0;
      dout   <= '0;
    end else begin
      meta_r <= din;
      dout   <= meta_r;
    end
  end

endmodule : mms_sync

`default_nettype wire

// ==== rtl/mms_mode_dec.sv ====
// Decode of a latched mode code into bus and pin roles.
// Assumes the code is stable; unsupported codes clear valid and all roles.
`timescale 1ns/1ns
`default_nettype none
`include "mms_consts.svh"

module mms_mode_dec
  import mms_pkg::*;
(
  // Mode code
  input  wire mms_mode_t mode,
  // Roles
  output logic           valid,
  output logic           max_mode,
  output logic           bus16,
  output logic           p1_data,
  output logic           p2_addr
);

  always_comb begin
    valid    = 1'b1;
    max_mode = 1'b0;
    bus16    = 1'b0;
    p1_data  = 1'b0;
    p2_addr  = 1'b0;
    case (mode)
      `MMS_MODE1: begin
      end
      `MMS_MODE2: begin
        bus16   = 1'b1;
        p1_data = 1'b1;
      end
      `MMS_MODE3: begin
        max_mode = 1'b1;
        p2_addr  = 1'b1;
      end
      `MMS_MODE4: begin
        max_mode = 1'b1;
        bus16    = 1'b1;
        p1_data  = 1'b1;
        p2_addr  = 1'b1;
      end
      default: begin
        valid = 1'b0;
      end
    endcase
  end

endmodule : mms_mode_dec

`default_nettype wire

// ==== rtl/mms_top.sv ====
// Mode select, mode readback register and port pin map.
// Assumes an APB master on pclk and mode pins held through reset.
//
// Functional notes
// R1: An 8-bit readback register is readable; writes change nothing.
// R2: Bits 7 and 6 of the readback always read as one.
// R3: Bits 5 to 3 of the readback always read as zero.
// R4: Bits 2 to 0 show mode pins 2 to 0 in the same order.
// R5: Mode 1 gives a 64 KB space, 8-bit bus, byte area ignored.
// R6: Mode 2 gives a 64 KB space, 16-bit bus, byte area 8-bit.
// R7: Mode 3 gives a 16 MB space, 8-bit bus, byte area ignored.
// R8: Mode 4 gives a 16 MB space, 16-bit bus, byte area 8-bit.
// R9: Port 1 carries data bits 7 to 0 in modes 2 and 4 only.
// R10: Port 2 drives address bits 23 to 16 in modes 3 and 4 only.
// R11: Ports 4, 7, 8 and port 5 low nibble also serve peripherals.
// R12: Minimum or maximum CPU mode follows the mode pins.
// R13: Maximum mode forms 24-bit addresses from four 64 KB pages.
// R14: Only mode codes 1 to 4 may be applied to the mode pins.
// R15: The mode is caught after reset and held until next reset.
//
// Implementation choice: the APB register port.
`timescale 1ns/1ns
`default_nettype none
`include "mms_consts.svh"

module mms_top
  import mms_pkg::*;
(
  // APB
  input  wire logic [`MMS_ADDR_W-1:0] paddr,
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [31:0]            pwdata,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  // Mode pins
  input  wire logic                   mode_pin2,
  input  wire logic                   mode_pin1,
  input  wire logic                   mode_pin0,
  // Mode status
  output logic                        mode_locked,
  output logic                        mode_valid,
  output logic                        cpu_max_mode,
  // Bus controller side
  input  wire logic                   byte_area_hit,
  input  wire logic [1:0]             page_sel,
  input  wire logic [7:0]             page_code,
  input  wire logic [7:0]             page_data,
  input  wire logic [7:0]             page_ext,
  input  wire logic [7:0]             page_stack,
  input  wire logic [15:0]            addr_off,
  input  wire logic [7:0]             dbus_lo_out,
  input  wire logic [7:0]             dbus_lo_oe,
  output logic [7:0]                  dbus_lo_in,
  output logic                        acc_8bit,
  output logic [23:0]                 eff_addr,
  // Port 1
  input  wire logic [7:0]             p1_in,
  input  wire logic [7:0]             gpio1_out,
  input  wire logic [7:0]             gpio1_oe,
  output logic [7:0]                  gpio1_in,
  output logic [7:0]                  p1_out,
  output logic [7:0]                  p1_oe,
  // Port 2
  input  wire logic [7:0]             gpio2_out,
  input  wire logic [7:0]             gpio2_oe,
  output logic [7:0]                  p2_out,
  output logic [7:0]                  p2_oe,
  // Shared ports: 4, 8, 5 low nibble
  input  wire logic [19:0]            sh_per_en,
  input  wire logic [19:0]            sh_per_out,
  input  wire logic [19:0]            sh_per_oe,
  input  wire logic [19:0]            sh_gpio_out,
  input  wire logic [19:0]            sh_gpio_oe,
  output logic [19:0]                 sh_out,
  output logic [19:0]                 sh_oe,
  // Port 7, input only
  input  wire logic [3:0]             p7_in,
  output logic [3:0]                  p7_in_s
);

  ////////////////////////////////////////////////////////////
  // Pin synchronisers

  mms_mode_t mode_s;
  logic [7:0] p1_s;

  mms_sync #(.W(3)) u_mode_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     ({mode_pin2, mode_pin1, mode_pin0}),
    .dout    (mode_s)
  );

  mms_sync #(.W(8)) u_p1_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (p1_in),
    .dout    (p1_s)
  );

  // Port 7 feeds GPIO and peripherals alike
  mms_sync #(.W(4)) u_p7_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (p7_in),
    .dout    (p7_in_s) // see R11
  );

  ////////////////////////////////////////////////////////////
  // Mode capture

  mms_lock_t lk_r;
  mms_lock_t lk_nxt;
  logic [1:0] settle_r;
  mms_mode_t mode_r;

  // Wait out the synchroniser before trusting pins
  always_comb begin
    lk_nxt = lk_r;
    case (lk_r)
      MMS_LK_SETTLE: begin
        if (settle_r == `MMS_SETTLE_CYC)
          lk_nxt = MMS_LK_CAPTURE;
      end
      MMS_LK_CAPTURE: begin
        lk_nxt = MMS_LK_HELD;
      end
      MMS_LK_HELD: begin
        lk_nxt = MMS_LK_HELD;
      end
      default: begin
        lk_nxt = MMS_LK_SETTLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lk_r <= MMS_LK_SETTLE;
    end else begin
      lk_r <= lk_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_r <= 2'h0;
    end else if (lk_r == MMS_LK_SETTLE) begin
      settle_r <= settle_r + 2'h1;
    end
  end

  // Pin changes after capture are ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= `MMS_MODE_RST;
    end else if (lk_r == MMS_LK_CAPTURE) begin
      mode_r <= mode_s; // see R15 see R12
    end
  end

  logic valid_d;
  logic max_d;
  logic bus16_d;
  logic p1_data_d;
  logic p2_addr_d;

  mms_mode_dec u_dec (
    .mode     (mode_r),
    .valid    (valid_d),
    .max_mode (max_d),
    .bus16    (bus16_d),
    .p1_data  (p1_data_d),
    .p2_addr  (p2_addr_d)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_locked  <= 1'b0;
      mode_valid   <= 1'b0;
      cpu_max_mode <= 1'b0;
    end else begin
      mode_locked  <= (lk_r == MMS_LK_HELD);
      mode_valid   <= valid_d; // see R14
      cpu_max_mode <= max_d; // see R12
    end
  end

  ////////////////////////////////////////////////////////////
  // APB slave, no wait states

  logic       setup;
  logic       hit;
  logic [7:0] rb;

  assign setup = psel & ~penable;
  assign hit   = (paddr == `MMS_RB_ADDR);
  // Constant fields are wired, so no write can reach them
  assign rb = {`MMS_RB_HI_VAL, `MMS_RB_MID_VAL, // see R2 see R3
               mode_r}; // see R4

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~hit;
      if (setup)
        prdata <= (hit & ~pwrite) ? {24'h0, rb} : 32'h0; // see R1
    end
  end

  ////////////////////////////////////////////////////////////
  // Access width and effective address

  logic [7:0] page;

  always_comb begin
    case (page_sel)
      `MMS_PG_CODE:  page = page_code;
      `MMS_PG_DATA:  page = page_data;
      `MMS_PG_EXT:   page = page_ext;
      `MMS_PG_STACK: page = page_stack;
      default:       page = 8'h00;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_8bit <= 1'b1;
      eff_addr <= 24'h0;
    end else begin
      // Byte area only matters on a 16-bit bus
      acc_8bit <= ~bus16_d | byte_area_hit; // see R5 see R6 see R7 see R8
      // Minimum mode stays in page zero
      eff_addr <= {max_d ? page : 8'h00, addr_off}; // see R13 see R12
    end
  end

  ////////////////////////////////////////////////////////////
  // Pin map

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p1_out     <= 8'h00;
      p1_oe      <= 8'h00;
      gpio1_in   <= 8'h00;
      dbus_lo_in <= 8'h00;
    end else begin
      p1_out     <= p1_data_d ? dbus_lo_out : gpio1_out; // see R9
      p1_oe      <= p1_data_d ? dbus_lo_oe : gpio1_oe; // see R9
      gpio1_in   <= p1_data_d ? 8'h00 : p1_s;
      dbus_lo_in <= p1_data_d ? p1_s : 8'h00;
    end
  end

  // Address byte lags eff_addr by one clock, the page pick by two
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p2_out <= 8'h00;
      p2_oe  <= 8'h00;
    end else begin
      p2_out <= p2_addr_d ? eff_addr[23:16] : gpio2_out; // see R10
      p2_oe  <= p2_addr_d ? 8'hff : gpio2_oe; // see R10
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_out <= 20'h0;
      sh_oe  <= 20'h0;
    end else begin
      sh_out <= (sh_per_en & sh_per_out) |
                (~sh_per_en & sh_gpio_out); // see R11
      sh_oe  <= (sh_per_en & sh_per_oe) |
                (~sh_per_en & sh_gpio_oe); // see R11
    end
  end

  ////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic rd_done;
  logic wr_done;
  assign rd_done = psel & penable & pready & ~pwrite & ~pslverr;
  assign wr_done = psel & penable & pready & pwrite & ~pslverr;

  rb_write_a: assert property ( // see R1
    wr_done |=> $stable(mode_r) && !pslverr
  ) else $error("readback changed by a write");

  rb_ones_a: assert property ( // see R2
    rd_done |-> prdata[7:6] == 2'h3 && prdata[31:8] == 24'h0
  ) else $error("readback top bits not one");

  rb_zeros_a: assert property ( // see R3
    rd_done |-> prdata[5:3] == 3'h0
  ) else $error("readback middle bits not zero");

  rb_pins_a: assert property ( // see R4
    rd_done |-> prdata[2:0] == mode_r
  ) else $error("readback mode bits wrong");

  mode1_width_a: assert property ( // see R5
    mode_r == 3'h1 |=> acc_8bit
  ) else $error("mode 1 not 8-bit");

  mode2_width_a: assert property ( // see R6
    mode_r == 3'h2 && $stable(mode_r)
      |=> acc_8bit == $past(byte_area_hit)
  ) else $error("mode 2 width wrong");

  mode3_width_a: assert property ( // see R7
    mode_r == 3'h3 |=> acc_8bit
  ) else $error("mode 3 not 8-bit");

  mode4_width_a: assert property ( // see R8
    mode_r == 3'h4 && $stable(mode_r)
      |=> acc_8bit == $past(byte_area_hit)
  ) else $error("mode 4 width wrong");

  port1_data_a: assert property ( // see R9
    (mode_r == 3'h2 || mode_r == 3'h4) && $stable(mode_r)
      |=> p1_out == $past(dbus_lo_out)
  ) else $error("port 1 not data bus");

  port2_addr_a: assert property ( // see R10
    (mode_r == 3'h3 || mode_r == 3'h4) && $stable(mode_r)
      |=> p2_oe == 8'hff ##1 p2_out == $past(eff_addr[23:16])
  ) else $error("port 2 not address bus");

  shared_pins_a: assert property ( // see R11
    sh_per_en == 20'hfffff |=> sh_out == $past(sh_per_out)
  ) else $error("peripheral pin not routed");

  min_page_a: assert property ( // see R12
    (mode_r == 3'h1 || mode_r == 3'h2) |=> eff_addr[23:16] == 8'h00
  ) else $error("minimum mode left page zero");

  stack_page_a: assert property ( // see R13
    mode_r == 3'h4 && page_sel == 2'h3 && $stable(mode_r)
      |=> eff_addr == {$past(page_stack), $past(addr_off)}
  ) else $error("stack page address wrong");

  mode_hold_a: assert property ( // see R15
    lk_r == MMS_LK_HELD |=> $stable(mode_r) && mode_locked
  ) else $error("mode changed after capture");

endmodule : mms_top

`default_nettype wire

// ==== tb/mms_ext_mem.sv ====
// Model of external memory on the expanded bus.
// Assumes port 2 carries the upper address whenever it drives all pins.
`timescale 1ns/1ns
`default_nettype none

module mms_ext_mem (
  // Device pins
  input  wire logic [7:0] p1_out,
  input  wire logic [7:0] p1_oe,
  input  wire logic [7:0] p2_out,
  input  wire logic [7:0] p2_oe,
  // Resolved port 1 level
  output logic      [7:0] p1_in
);
  logic [7:0] mem_q;

  // Unaddressed memory lets go; the pull-up wins
  assign mem_q = (p2_oe == 8'hff) ? (p2_out ^ 8'h5a) : 8'hff;
  // Wire level from both drivers
  assign p1_in = (p1_oe & p1_out) | (~p1_oe & mem_q);
endmodule : mms_ext_mem

`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench of the mode select and pin map block.
// Assumes the block's APB slave and an external memory model.
`timescale 1ns/1ns
`default_nettype none
`include "mms_consts.svh"

`define CHK(nm, e, a) begin n_compared++; if ((a) !== (e)) begin \
  error_cnt++; $display("MISMATCH %s exp %0h got %0h", nm, e, a); end end

module tb_top
  import mms_pkg::*;
;
  typedef struct packed {
    logic [2:0]  m;
    logic        mx, p1d, p2a;
    logic [7:0]  lo, g1;
    logic [23:0] ea;
  } mms_tb_row_t;
  logic [`MMS_ADDR_W-1:0] paddr;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [31:0] pwdata, prdata, rd;
  logic        mode_pin2, mode_pin1, mode_pin0, mode_locked, mode_valid;
  logic        cpu_max_mode, byte_area_hit, acc_8bit;
  logic [1:0]  page_sel;
  logic [7:0]  page_code, page_data, page_ext, page_stack, dbus_lo_out;
  logic [7:0]  dbus_lo_oe, dbus_lo_in, p1_in, gpio1_out, gpio1_oe, gpio1_in;
  logic [7:0]  p1_out, p1_oe, gpio2_out, gpio2_oe, p2_out, p2_oe;
  logic [15:0] addr_off;
  logic [23:0] eff_addr;
  logic [19:0] sh_per_en, sh_per_out, sh_per_oe, sh_gpio_out, sh_gpio_oe;
  logic [19:0] sh_out, sh_oe;
  logic [3:0]  p7_in, p7_in_s;
  int          error_cnt, n_compared;
  int          cyc = 0;
  // Peripheral enables and the pin drive and enable each must give
  logic [19:0] sh_en [3] = '{20'h0f0f0, 20'hf0f0f, 20'hfffff};
  logic [19:0] sh_o [3] = '{20'h5a5a5, 20'ha5a5a, 20'haaaaa};
  logic [19:0] sh_e [3] = '{20'h0fff0, 20'hf0f0f, 20'hfffff};
  logic [7:0]  pg [4] = '{8'h12, 8'h34, 8'h56, 8'h78};
  mms_tb_row_t rows [4] = '{
    '{3'h1, 1'b0, 1'b0, 1'b0, 8'h00, 8'hcf, 24'h0089ab},
    '{3'h2, 1'b0, 1'b1, 1'b0, 8'hf5, 8'h00, 24'h0089ab},
    '{3'h3, 1'b1, 1'b0, 1'b1, 8'h00, 8'hc8, 24'h1289ab},
    '{3'h4, 1'b1, 1'b1, 1'b1, 8'h45, 8'h00, 24'h1289ab}};

  mms_top dut (
    .paddr, .pclk, .presetn, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .mode_pin2, .mode_pin1, .mode_pin0, .mode_locked,
    .mode_valid, .cpu_max_mode, .byte_area_hit, .page_sel, .page_code,
    .page_data, .page_ext, .page_stack, .addr_off, .dbus_lo_out,
    .dbus_lo_oe, .dbus_lo_in, .acc_8bit, .eff_addr, .p1_in, .gpio1_out,
    .gpio1_oe, .gpio1_in, .p1_out, .p1_oe, .gpio2_out, .gpio2_oe, .p2_out,
    .p2_oe, .sh_per_en, .sh_per_out, .sh_per_oe, .sh_gpio_out,
    .sh_gpio_oe, .sh_out, .sh_oe, .p7_in, .p7_in_s);
  mms_ext_mem u_mem (.p1_out, .p1_oe, .p2_out, .p2_oe, .p1_in);

  initial pclk = 1'b0;
  always #10 pclk = ~pclk;

  ////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results

  // Hang guard well above the roughly 190 cycles needed
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      results();
    end
  end

  // No wait-state count assumed; the bound only guards a hang
  task automatic apb(input logic wr, input logic [19:0] a,
                     output logic [31:0] d, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    {psel, penable, pwrite} <= {2'b10, wr};
    paddr <= a;
    pwdata <= 32'hffff_ff07;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    d = prdata;
    e = pslverr;
    `CHK("pready", 1'b1, pready)
    {psel, penable} <= 2'b00;
  endtask : apb

  task automatic rb(input logic [7:0] x);
    apb(1'b0, `MMS_RB_ADDR, rd, err);
    `CHK("readback", {24'h0, x}, rd)
    `CHK("rb_err", 1'b0, err)
  endtask : rb

  // Pins held through reset and capture, as the mode logic needs
  task automatic rst(input logic [2:0] m);
    int n;
    presetn <= 1'b0;
    {mode_pin2, mode_pin1, mode_pin0} <= m;
    repeat (8) @(posedge pclk);
    `CHK("rst_acc8", 1'b1, acc_8bit)
    `CHK("rst_lock", 1'b0, mode_locked)
    presetn <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (mode_locked !== 1'b1 && n < 20);
    repeat (6) @(posedge pclk);
  endtask : rst

  ////////////////////////////////////////////////////////////////////
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {mode_pin2, mode_pin1, mode_pin0, byte_area_hit, page_sel} = '0;
    {page_code, page_data, page_ext, page_stack} =
      {pg[0], pg[1], pg[2], pg[3]};
    {addr_off, dbus_lo_out, dbus_lo_oe} = {16'h89ab, 8'ha5, 8'h0f};
    {gpio1_out, gpio1_oe, gpio2_out, gpio2_oe} = 32'hc3f0_7700;
    {sh_per_en, sh_per_out, sh_per_oe} = {20'h0f0f0, 20'haaaaa, 20'hfffff};
    {sh_gpio_out, sh_gpio_oe, p7_in} = {20'h55555, 20'h00f00, 4'h9};
    {error_cnt, n_compared} = '0;
    foreach (rows[i]) begin
      rst(rows[i].m);
      `CHK("locked", 1'b1, mode_locked)
      rb({5'b11000, rows[i].m});
      apb(1'b1, `MMS_RB_ADDR, rd, err);
      `CHK("wr_err", 1'b0, err)
      rb({5'b11000, rows[i].m});
      `CHK("valid", 1'b1, mode_valid)
      `CHK("max", rows[i].mx, cpu_max_mode)
      `CHK("acc8", ~rows[i].p1d, acc_8bit)
      `CHK("eff", rows[i].ea, eff_addr)
      `CHK("p1_oe", rows[i].p1d ? 8'h0f : 8'hf0, p1_oe)
      `CHK("p1_out", rows[i].p1d ? 8'ha5 : 8'hc3, p1_out)
      `CHK("lo_in", rows[i].lo, dbus_lo_in)
      `CHK("g1_in", rows[i].g1, gpio1_in)
      `CHK("p2_oe", rows[i].p2a ? 8'hff : 8'h00, p2_oe)
      `CHK("p2_out", rows[i].p2a ? pg[0] : 8'h77, p2_out)
      byte_area_hit <= 1'b1;
      repeat (3) @(posedge pclk);
      `CHK("acc8_hit", 1'b1, acc_8bit)
      byte_area_hit <= 1'b0;
      $display("mode %0d test done", rows[i].m);
    end
    // Four pages usable at once in maximum mode, mode 4 still set
    for (int s = 0; s < 4; s++) begin
      page_sel <= 2'(s);
      repeat (4) @(posedge pclk);
      `CHK("page_ea", {pg[s], 16'h89ab}, eff_addr)
      `CHK("page_p2", pg[s], p2_out)
    end
    apb(1'b0, 20'h00000, rd, err);
    `CHK("unmap_err", 1'b1, err)
    `CHK("unmap_rd", 32'h0, rd)
    apb(1'b1, 20'h00004, rd, err);
    `CHK("unmap_wr", 1'b1, err)
    {mode_pin2, mode_pin1, mode_pin0} <= 3'h1;
    repeat (6) @(posedge pclk);
    rb(8'hc4);
    `CHK("held_max", 1'b1, cpu_max_mode)
    $display("page, unmapped and hold tests done");
    for (int k = 0; k < 3; k++) begin
      sh_per_en <= sh_en[k];
      repeat (3) @(posedge pclk);
      `CHK("sh_out", sh_o[k], sh_out)
      `CHK("sh_oe", sh_e[k], sh_oe)
    end
    `CHK("p7", 4'h9, p7_in_s)
    rst(3'h5);
    rb(8'hc5);
    `CHK("bad_valid", 1'b0, mode_valid)
    `CHK("bad_acc8", 1'b1, acc_8bit)
    $display("shared port and bad mode tests done");
    results();
  end
endmodule : tb_top

`default_nettype wire
